/* bench/irq_core_model.sv */
// Processor core model taking presented interrupts
`timescale 1ns/1ps
module irq_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_req_i,
    input wire logic [5:0] irq_id_i,
    input wire logic slow_i,
    output logic irq_taken_o,
    output logic [5:0] taken_id_o
);
    logic [3:0] gap_ff;
    // ==========
    // Take one request, then ignore requests for 2 cycles, or 8 when slow_i is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_taken_o <= 1'b0;
            taken_id_o <= 6'h20;
            gap_ff <= 4'h0;
        end else begin
            irq_taken_o <= 1'b0;
            if (gap_ff != 4'h0) begin
                gap_ff <= gap_ff - 4'h1;
            end else if (irq_req_i && !irq_taken_o) begin
                irq_taken_o <= 1'b1;
                taken_id_o <= irq_id_i;
                gap_ff <= slow_i ? 4'h8 : 4'h2;
            end
        end
    end
endmodule : irq_core_model

/* bench/vectored_irq_ctrl_sva.sv */
// Port checker of the interrupt controller
`timescale 1ns/1ps
module vectored_irq_ctrl_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [3:0] sel_i,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic irq_taken_i,
    input wire logic irq_req_o,
    input wire irq_ctrl_pkg::irq_id_t irq_id_o,
    input wire logic irq_id_reserved_o,
    input wire logic core_power_on_o,
    input wire logic periph_power_on_o,
    input wire logic radio_event_i,
    input wire logic always_on_wake_pin_i,
    input wire logic sleep_timer_expired_i
);
    localparam logic [31:0] RSV = 32'h746A_9000;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // Properties
    property p_ack_lat; cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat)
        else $error("bus answer late");
    property p_err_sel;
        cyc_i && stb_i && !ack_o && !err_o && sel_i != 4'hF |=> err_o && !ack_o;
    endproperty
    a_err_sel: assert property (p_err_sel)
        else $error("partial access accepted");
    property p_ack_once; ack_o || err_o |=> !ack_o && !err_o; endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("answer too long");
    property p_idle_id; !irq_req_o |-> irq_id_o == 6'h20; endproperty
    a_idle_id: assert property (p_idle_id)
        else $error("id without request");
    property p_req_id; irq_req_o |-> irq_id_o < 6'h20; endproperty
    a_req_id: assert property (p_req_id)
        else $error("request id out of range");
    property p_rsv; irq_req_o |-> irq_id_reserved_o == RSV[irq_id_o[4:0]];
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved flag wrong");
    property p_power; !core_power_on_o |-> !periph_power_on_o; endproperty
    a_power: assert property (p_power)
        else $error("peripherals on while core is off");
    property p_wake_seq;
        $rose(core_power_on_o) |-> !periph_power_on_o ##1 periph_power_on_o;
    endproperty
    a_wake_seq: assert property (p_wake_seq)
        else $error("wake power order wrong");
    property p_wake;
        !core_power_on_o && (radio_event_i || always_on_wake_pin_i ||
        sleep_timer_expired_i) |=> core_power_on_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake event did not restart core");
    property p_taken; irq_req_o && irq_taken_i
        |-> ##2 (!irq_req_o || irq_id_o != $past(irq_id_o, 2)); endproperty
    a_taken: assert property (p_taken)
        else $error("taken line presented again");
    c_err: cover property (err_o);
    c_taken: cover property (irq_req_o && irq_taken_i);
    c_wake: cover property (!core_power_on_o ##1 core_power_on_o);
endmodule : vectored_irq_ctrl_sva
bind vectored_irq_ctrl vectored_irq_ctrl_sva vectored_irq_ctrl_sva_inst (
    .clk_i, .rst_i, .cyc_i, .stb_i, .sel_i, .ack_o, .err_o, .irq_taken_i,
    .irq_req_o, .irq_id_o, .irq_id_reserved_o, .core_power_on_o,
    .periph_power_on_o, .radio_event_i, .always_on_wake_pin_i,
    .sleep_timer_expired_i);

/* bench/vectored_irq_ctrl_tb.sv */
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
module vectored_irq_ctrl_tb;
    import irq_ctrl_pkg::*;
    localparam word_t RSV_MAP = 32'h746A_9000;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, tk, slow, rq;
    logic cpw, ppw, wirq, rsv;
    logic [1:0] prio;
    logic [2:0] exp_rp;
    logic [1:0] exp_p[$];
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [2:0] wev;
    logic [4:0] o;
    logic [4:0] mux[23];
    word_t dat_i, dat_o, src, line, r;
    irq_id_t id, tid;
    logic [32:0] exp_b[$];
    irq_id_t exp_id[$];
    int n_fail = 0;
    int check_count = 0;
    vectored_irq_ctrl vectored_irq_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .src_irq_i(src), .line_irq_i(line),
        .radio_event_i(wev[0]), .always_on_wake_pin_i(wev[1]),
        .sleep_timer_expired_i(wev[2]), .irq_taken_i(tk), .irq_req_o(rq),
        .irq_id_o(id), .irq_prio_o(prio), .irq_id_reserved_o(rsv),
        .core_power_on_o(cpw), .periph_power_on_o(ppw), .wake_irq_o(wirq));
    irq_core_model irq_core_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .irq_req_i(rq), .irq_id_i(id), .slow_i(slow), .irq_taken_o(tk),
        .taken_id_o(tid));
    // ==========
    // Tasks
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic fail_out;
        n_fail++;
        report_and_stop();
    endtask : fail_out
    task automatic bus(input logic w, input logic [7:0] a, input word_t d,
            input logic [3:0] s, input logic e);
        exp_b.push_back({e, (w | e) ? 32'h0 : d});
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
        for (int i = 0; i <= 20; i++) begin
            @(posedge clk_i);
            if (ack_o | err_o) break;
            if (i == 20) fail_out();
        end
        {cyc_i, stb_i} <= 2'b00;
    endtask : bus
    task automatic wr(input logic [7:0] a, input word_t d);
        bus(1'b1, a, d, 4'hF, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input word_t d);
        bus(1'b0, a, d, 4'hF, 1'b0);
    endtask : rd
    task automatic wait_for(input bit pw);
        for (int i = 0; i <= 100; i++) begin
            @(posedge clk_i);
            if (pw ? cpw === 1'b1 : exp_id.size() == 0) break;
            if (i == 100) fail_out();
        end
    endtask : wait_for
    function automatic word_t hits(input logic [4:0] opt);
        hits = 32'h0;
        for (int l = 0; l < 23; l++) hits[l] = (mux[l] == opt);
    endfunction : hits
    // ==========
    // Monitor
    always @(posedge clk_i) begin
        if (ack_o | err_o)
            check({err_o, (we_i | err_o) ? 32'h0 : dat_o}, exp_b.pop_front());
        if (tk)
            check({27'h0, tid}, {27'h0, exp_id.pop_front()});
        if (tk) begin
            exp_rp = {RSV_MAP[tid[4:0]], exp_p.pop_front()};
            check({30'h0, rsv, prio}, {30'h0, exp_rp});
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ==========
    // Sequence
    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, src, line, wev, slow} = '0;
        rst_i = 1'b1;
        for (int l = 0; l < 23; l++) mux[l] = (l < 12) ? 5'(l + 1) : 5'h0;
        {mux[13], mux[14], mux[20]} = {5'h0E, 5'h0F, 5'h18};
        void'($urandom(32'hD111));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h08, 32'h0);
        rd(8'h40, 32'h746A_9000);
        bus(1'b0, 8'h44, 32'h0, 4'hF, 1'b1);
        bus(1'b1, 8'h00, 32'hFFFF_FFFF, 4'h3, 1'b1);
        r = $urandom();
        wr(8'h00, r);
        wr(8'h00, 32'h1);
        rd(8'h04, r | 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h04, r);
        rd(8'h00, 32'h1 & ~r);
        wr(8'h04, 32'hFFFF_FFFF);
        $display("test 1 done");
        for (int k = 0; k < 5; k++) begin
            r = $urandom_range(11);
            o = 5'($urandom_range(24, 1));
            wr({1'b1, r[4:0], 2'b00}, {27'h0, o});
            mux[r[4:0]] = o;
            @(posedge clk_i);
            {src, line} <= {32'h1 << o, (k == 4) ? r << 23 : 32'h0};
            @(posedge clk_i);
            {src, line} <= 64'h0;
            rd(8'h0C, hits(o) | ((k == 4) ? r << 23 : 32'h0));
            check({32'h0, rq}, 33'h0);
            wr(8'h0C, 32'hFFFF_FFFF);
        end
        $display("test 2 done");
        for (int k = 0; k < 2; k++) begin
            slow <= k[0];
            wr(8'h10, k ? 32'h0 : 32'hC000_0000);
            wr(8'h08, 32'h28);
            exp_id.push_back(k ? 6'd3 : 6'd5);
            exp_id.push_back(k ? 6'd5 : 6'd3);
            exp_p.push_back(2'h0);
            exp_p.push_back(k ? 2'h0 : 2'h3);
            wr(8'h00, 32'h28);
            wait_for(1'b0);
            rd(8'h30, 32'h28);
            wr(8'h04, 32'h28);
            wr(8'h0C, 32'h28);
            wr(8'h30, 32'h28);
            rd(8'h30, 32'h0);
        end
        $display("test 3 done");
        wr(8'h38, 32'h7);
        for (int k = 0; k < 3; k++) begin
            wr(8'h3C, 32'h1);
            @(posedge clk_i);
            check({31'h0, cpw, ppw}, 33'h0);
            wev <= 3'(1 << k);
            @(posedge clk_i);
            wev <= 3'h0;
            wait_for(1'b1);
            rd(8'h34, 32'h1 << k);
            check({32'h0, wirq}, 33'h1);
            wr(8'h34, 32'h7);
            @(posedge clk_i);
            check({32'h0, wirq}, 33'h0);
        end
        $display("test 4 done");
        report_and_stop();
    end
endmodule : vectored_irq_ctrl_tb

/* rtl/irq_ctrl_defines.svh */
// Register offsets, field layouts and reset values of the interrupt controller
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

`define IRQ_NUM 32
`define IRQ_PRIO_W 2
`define IRQ_SEL_W 5
`define IRQ_MUX_NUM 23
`define IRQ_OPT_MAX 5'h18
`define ADR_ENABLE_SET 8'h00
`define ADR_ENABLE_CLR 8'h04
`define ADR_PEND_SET 8'h08
`define ADR_PEND_CLR 8'h0C
`define ADR_PRIO_BASE 8'h10
`define ADR_PRIO_LAST 8'h2C
`define ADR_ACTIVE 8'h30
`define ADR_WAKE_STAT 8'h34
`define ADR_WAKE_MASK 8'h38
`define ADR_LP_CTRL 8'h3C
`define ADR_RESERVED_MAP 8'h40
`define ADR_MUX_BASE 8'h80
`define ADR_MUX_LAST 8'hD8
`define RESERVED_MAP 32'h746A_9000
`define NOT_MUXABLE 32'hFF80_0000
`define WAKE_RADIO 0
`define WAKE_PIN 1
`define WAKE_TIMER 2
`define WAKE_W 3
`define NO_IRQ 6'h20

`endif

/* rtl/irq_ctrl_pkg.sv */
// Types shared by the interrupt controller
package irq_ctrl_pkg;
    typedef logic [31:0] word_t;
    typedef logic [5:0] irq_id_t;
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_ULP = 2'b01,
        PWR_WAKE = 2'b10
    } pwr_state_e;
endpackage : irq_ctrl_pkg

/* rtl/vectored_irq_ctrl.sv */
// Vectored interrupt controller with wake logic and Wishbone registers
//
// What this block does
// R1 - Takes 32 request lines, presents best pending one
// R2 - Per-input writable priority arbitrates pending requests
// R3 - Per-input enable; disabled inputs never forwarded
// R4 - Requests latch pending until software clears
// R5 - Registers use whole 32-bit little-endian words
// R6 - Inputs 0-11 serial port requests, remappable
// R7 - Fixed inputs 12-31; 23-31 not remappable
// R8 - Software avoids handlers on reserved inputs
// R9 - Reserved inputs flagged for resident firmware
// R10 - Radio, wake pin, sleep timer restart system
// R11 - Ultra-low-power powers down core and peripherals; radio, pin, timer still wake
// R12 - Remappable inputs choose source by option code
// R13 - Separate set and clear registers, zero ignored
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"

module vectored_irq_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire irq_ctrl_pkg::word_t dat_i,
    output irq_ctrl_pkg::word_t dat_o,
    output logic ack_o,
    output logic err_o,
    // Peripheral sources, indexed by option code (bit 0 unused)
    input wire logic [31:0] src_irq_i,
    // Fixed lines 12 to 31
    input wire logic [31:0] line_irq_i,
    // Wake sources
    input wire logic radio_event_i,
    input wire logic always_on_wake_pin_i,
    input wire logic sleep_timer_expired_i,
    // Core side
    input wire logic irq_taken_i,
    output logic irq_req_o,
    output irq_ctrl_pkg::irq_id_t irq_id_o,
    output logic [1:0] irq_prio_o,
    output logic irq_id_reserved_o,
    output logic core_power_on_o,
    output logic periph_power_on_o,
    output logic wake_irq_o
);
    import irq_ctrl_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    word_t enable_ff;
    word_t pending_ff;
    word_t active_ff;
    logic [`IRQ_PRIO_W-1:0] prio_ff [`IRQ_NUM];
    logic [`IRQ_SEL_W-1:0] mux_ff [`IRQ_MUX_NUM];
    logic [`WAKE_W-1:0] wake_stat_ff;
    logic [`WAKE_W-1:0] wake_mask_ff;
    pwr_state_e pwr_ff;
    logic ack_ff;
    logic err_ff;
    word_t rdata_ff;

    word_t req_lines;
    logic bus_req;
    logic wr_ok;
    logic rd_ok;
    logic addr_hit;
    logic full_word;
    logic [7:0] idx;

    // ==========================================================
    // Bus decode
    // ==========================================================
    assign bus_req = cyc_i && stb_i && !ack_ff && !err_ff;
    assign full_word = (sel_i == 4'hF); // R5
    assign idx = adr_i;
    always_comb begin
        addr_hit = 1'b0;
        if (adr_i[1:0] == 2'b00) begin
            if (adr_i <= `ADR_RESERVED_MAP) begin
                addr_hit = 1'b1;
            end else if (adr_i >= `ADR_MUX_BASE &&
                         adr_i <= `ADR_MUX_LAST) begin
                addr_hit = 1'b1;
            end
        end
    end
    assign wr_ok = bus_req && we_i && addr_hit && full_word;
    assign rd_ok = bus_req && !we_i && addr_hit && full_word;

    // ==========================================================
    // Source selection
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < `IRQ_NUM; g++) begin : g_line
            if (g < `IRQ_MUX_NUM) begin : g_mux
                // Lines 12 to 22 fall back to their fixed wire
                logic fixed_wire;
                assign fixed_wire = (g >= 12) ? line_irq_i[g] : 1'b0; // R7
                // R6 R12
                assign req_lines[g] =
                    (mux_ff[g] != 5'h00 && mux_ff[g] <= `IRQ_OPT_MAX) ?
                    src_irq_i[mux_ff[g]] : fixed_wire;
            end else begin : g_fix
                assign req_lines[g] = line_irq_i[g]; // R7
            end
        end
    endgenerate

    // ==========================================================
    // Enable, pending and active
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_ff <= 32'h0000_0000;
        end else if (wr_ok && adr_i == `ADR_ENABLE_SET) begin
            enable_ff <= enable_ff | dat_i; // R13
        end else if (wr_ok && adr_i == `ADR_ENABLE_CLR) begin
            enable_ff <= enable_ff & ~dat_i; // R3 R13
        end
    end

    word_t take_mask;
    always_comb begin
        take_mask = 32'h0000_0000;
        if (irq_taken_i && irq_req_o) begin
            take_mask[irq_id_o[4:0]] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_ff <= 32'h0000_0000;
        end else begin
            // Requests win over a clear in the same cycle
            if (wr_ok && adr_i == `ADR_PEND_SET) begin
                pending_ff <= pending_ff | dat_i | req_lines; // R13
            end else if (wr_ok && adr_i == `ADR_PEND_CLR) begin
                pending_ff <= (pending_ff & ~dat_i) | req_lines; // R4
            end else begin
                pending_ff <= pending_ff | req_lines; // R4
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_ff <= 32'h0000_0000;
        end else if (wr_ok && adr_i == `ADR_ACTIVE) begin
            active_ff <= (active_ff & ~dat_i) | take_mask;
        end else begin
            active_ff <= active_ff | take_mask;
        end
    end

    // ==========================================================
    // Priority and mux registers
    // ==========================================================
    generate
        for (g = 0; g < `IRQ_NUM; g++) begin : g_prio
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    prio_ff[g] <= 2'h0;
                end else if (wr_ok &&
                             adr_i == `ADR_PRIO_BASE + 8'(4 * (g / 4))) begin
                    // Top bits of each byte lane, as in a 4-per-word map
                    prio_ff[g] <= dat_i[8 * (g % 4) + 6 +: 2]; // R2 R5
                end
            end
        end
        for (g = 0; g < `IRQ_MUX_NUM; g++) begin : g_msel
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mux_ff[g] <= (g < 12) ? 5'(g + 1) :
                                 (g == 13) ? 5'h0E :
                                 (g == 14) ? 5'h0F :
                                 (g == 20) ? 5'h18 : 5'h00;
                end else if (wr_ok &&
                             adr_i == `ADR_MUX_BASE + 8'(4 * g)) begin
                    mux_ff[g] <= dat_i[`IRQ_SEL_W-1:0]; // R12
                end
            end
        end
    endgenerate

    // ==========================================================
    // Arbitration
    // ==========================================================
    word_t cand;
    irq_id_t best_id;
    logic [1:0] best_prio;
    assign cand = pending_ff & enable_ff & ~active_ff; // R3
    always_comb begin
        best_id = `NO_IRQ;
        best_prio = 2'h3;
        // Lower value wins; lower index wins a tie
        for (int i = `IRQ_NUM - 1; i >= 0; i--) begin
            if (cand[i] && prio_ff[i] <= best_prio) begin // R2
                best_id = 6'(i);
                best_prio = prio_ff[i];
            end
        end
    end

    logic present;
    word_t rsv_map;
    assign rsv_map = `RESERVED_MAP;
    // A line just taken is withheld until its active bit shows
    assign present = (best_id != `NO_IRQ) && !take_mask[best_id[4:0]];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_req_o <= 1'b0;
            irq_id_o <= `NO_IRQ;
            irq_prio_o <= 2'h0;
            irq_id_reserved_o <= 1'b0;
        end else begin
            irq_req_o <= present; // R1
            if (present) begin
                irq_id_o <= best_id; // R1
                irq_prio_o <= best_prio;
                irq_id_reserved_o <= rsv_map[best_id[4:0]]; // R9
            end else begin
                irq_id_o <= `NO_IRQ;
                irq_prio_o <= 2'h0;
                irq_id_reserved_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Wake logic
    // ==========================================================
    logic [`WAKE_W-1:0] wake_ev;
    assign wake_ev = {sleep_timer_expired_i, always_on_wake_pin_i,
                      radio_event_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_stat_ff <= 3'h0;
        end else if (wr_ok && adr_i == `ADR_WAKE_STAT) begin
            wake_stat_ff <= (wake_stat_ff & ~dat_i[`WAKE_W-1:0]) | wake_ev;
        end else begin
            wake_stat_ff <= wake_stat_ff | wake_ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_mask_ff <= 3'h0;
        end else if (wr_ok && adr_i == `ADR_WAKE_MASK) begin
            wake_mask_ff <= dat_i[`WAKE_W-1:0];
        end
    end

    assign wake_irq_o = |(wake_stat_ff & wake_mask_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_ff <= PWR_RUN;
        end else begin
            case (pwr_ff)
                PWR_RUN: begin
                    if (wr_ok && adr_i == `ADR_LP_CTRL && dat_i[0]) begin
                        pwr_ff <= PWR_ULP;
                    end
                end
                PWR_ULP: begin
                    if (|wake_ev) begin
                        pwr_ff <= PWR_WAKE; // R10
                    end
                end
                PWR_WAKE: begin
                    pwr_ff <= PWR_RUN;
                end
                default: begin
                    pwr_ff <= PWR_RUN;
                end
            endcase
        end
    end

    assign core_power_on_o = (pwr_ff != PWR_ULP); // R11
    assign periph_power_on_o = (pwr_ff == PWR_RUN); // R11

    // ==========================================================
    // Bus answer
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req && addr_hit && full_word;
            err_ff <= bus_req && !(addr_hit && full_word);
        end
    end

    word_t rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (adr_i)
            `ADR_ENABLE_SET, `ADR_ENABLE_CLR: rd_mux = enable_ff;
            `ADR_PEND_SET, `ADR_PEND_CLR: rd_mux = pending_ff;
            `ADR_ACTIVE: rd_mux = active_ff;
            `ADR_WAKE_STAT: rd_mux = {29'h0, wake_stat_ff};
            `ADR_WAKE_MASK: rd_mux = {29'h0, wake_mask_ff};
            `ADR_LP_CTRL: rd_mux = {30'h0, pwr_ff};
            `ADR_RESERVED_MAP: rd_mux = `RESERVED_MAP; // R9
            default: begin
                if (adr_i >= `ADR_PRIO_BASE && adr_i <= `ADR_PRIO_LAST) begin
                    for (int k = 0; k < 4; k++) begin
                        rd_mux[8 * k + 6 +: 2] =
                            prio_ff[(32'(idx - `ADR_PRIO_BASE)) + k];
                    end
                end else if (adr_i >= `ADR_MUX_BASE &&
                             adr_i <= `ADR_MUX_LAST) begin
                    rd_mux[`IRQ_SEL_W-1:0] =
                        mux_ff[5'((idx - `ADR_MUX_BASE) >> 2)];
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_ok) begin
            rdata_ff <= rd_mux; // R5
        end
    end

    assign ack_o = ack_ff;
    assign err_o = err_ff;
    assign dat_o = rdata_ff;
endmodule : vectored_irq_ctrl
